/* sim/lvsr_regs_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module lvsr_regs_chk (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic o_line_polarity_sel,
    input wire logic [5:0] o_onhook_voltage_level,
    input wire logic [5:0] o_high_battery_level,
    input wire logic [5:0] o_low_battery_level,
    input wire logic [2:0] o_power_monitor_select,
    input wire logic o_manual_differential,
    input wire logic o_manual_common_mode
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);
    // update lands only if manual mode holds a cycle on
    sequence oh_wr_man;
        i_wr && i_addr == 8'h48 ##1 o_manual_differential;
    endsequence
    pol_rsv_a: assert property (i_rd && i_addr == 8'h48 |=> !o_rdata[7])
        else $error("onhook bit 7 not zero");
    cm_rsv_a: assert property (i_rd && i_addr == 8'h49 |=> o_rdata[7:6] == 2'b00)
        else $error("common mode top bits not zero");
    sel_rsv_a: assert property (i_rd && i_addr == 8'h4c |=> o_rdata[7:3] == 5'h00)
        else $error("selector top bits not zero");
    hb_copy_a: assert property (i_wr && i_addr == 8'h4a |=>
        ##1 o_high_battery_level == 6'($past(i_wdata, 2))) else $error("high battery late");
    lb_copy_a: assert property (i_wr && i_addr == 8'h4b |=>
        ##1 o_low_battery_level == 6'($past(i_wdata, 2))) else $error("low battery late");
    sel_copy_a: assert property (i_wr && i_addr == 8'h4c |=>
        ##1 o_power_monitor_select == 3'($past(i_wdata, 2))) else $error("selector late");
    man_bits_a: assert property (i_wr && i_addr == 8'h44 |=>
        {o_manual_common_mode, o_manual_differential} == 2'($past(i_wdata) >> 5))
        else $error("manual bits wrong");
    oh_follow_a: assert property (oh_wr_man |=>
        {o_line_polarity_sel, o_onhook_voltage_level} == 7'($past(i_wdata, 2)))
        else $error("onhook output not following");
endmodule
bind lvsr_regs lvsr_regs_chk chk_i (.*);
`default_nettype wire

/* sim/lvsr_regs_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module lvsr_regs_tb;
    logic i_sys_clk, i_reset_n, i_wr, i_rd, o_line_polarity_sel;
    logic o_manual_differential, o_manual_common_mode;
    logic [7:0] i_addr, i_wdata, o_rdata;
    logic [47:0] i_power;
    logic [5:0] o_onhook_voltage_level, o_common_mode_level, o_high_battery_level;
    logic [5:0] o_low_battery_level;
    logic [2:0] o_power_monitor_select;
    logic [7:0] ra [5] = '{8'h20, 8'h02, 8'h32, 8'h10, 8'h00};
    logic [7:0] wa [5] = '{8'h7d, 8'h3d, 8'h3d, 8'h3d, 8'h05};
    int error_cnt = 0;
    int checked = 0;
    lvsr_regs dut (.*);
    initial begin
        i_sys_clk = 1'b0;
        forever #10 i_sys_clk = ~i_sys_clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_sys_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1;
        chk(o_rdata, exp);
        idle(1);
        chk(o_rdata, 8'h00);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // guard against a hung run
    initial begin
        #100000;
        error_cnt++;
        close_out();
    end
    initial begin
        {i_reset_n, i_wr, i_rd, i_addr, i_wdata} = '0;
        i_power = 48'h6655_4433_2211;
        repeat (2) @(posedge i_sys_clk);
        i_reset_n <= 1'b1;
        for (int k = 0; k < 5; k++) begin
            rd(8'h48 + 8'(k), ra[k]);
            wr(8'h48 + 8'(k), 8'hfd);
            rd(8'h48 + 8'(k), wa[k]);
        end
        wr(8'h50, 8'hff);
        rd(8'h50, 8'h00);
        $display("reset and access test done");
        for (int s = 0; s < 6; s++) begin
            wr(8'h4c, 8'(s));
            idle(1);
            rd(8'h4d, 8'(8'h11 * (s + 1)));
        end
        $display("power monitor test done");
        chk({1'b0, o_line_polarity_sel, o_onhook_voltage_level}, 8'h20);
        wr(8'h44, 8'h20);
        idle(2);
        chk({1'b0, o_line_polarity_sel, o_onhook_voltage_level}, 8'h7d);
        chk({2'b00, o_common_mode_level}, 8'h02);
        wr(8'h44, 8'h60);
        idle(2);
        chk({2'b00, o_common_mode_level}, 8'h3d);
        rd(8'h44, 8'h60);
        wr(8'h48, 8'h0a);
        idle(2);
        chk({1'b0, o_line_polarity_sel, o_onhook_voltage_level}, 8'h0a);
        $display("manual control test done");
        wr(8'h4a, 8'h3e);
        wr(8'h4b, 8'h10);
        idle(2);
        chk({2'b00, o_high_battery_level}, 8'h3e);
        chk({2'b00, o_low_battery_level}, 8'h10);
        chk({5'h00, o_power_monitor_select}, 8'h05);
        $display("battery test done");
        close_out();
    end
endmodule
`default_nettype wire

/* verilog/lvsr_level_reg.sv */
`timescale 1ns/100ps
`default_nettype none
module lvsr_level_reg #(
    parameter logic [5:0] RESET_VAL = 6'h00
) (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_we,
    input wire logic [5:0] i_wdata,
    output logic [5:0] o_level
);
    logic [5:0] level_q;
    logic [5:0] level_d;
    always_comb begin
        level_d = i_we ? i_wdata : level_q;
    end
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            level_q <= RESET_VAL;
        end else begin
            level_q <= level_d;
        end
    end
    assign o_level = level_q;
endmodule
`default_nettype wire

/* verilog/lvsr_pkg.sv */
package lvsr_pkg;
    localparam logic [7:0] ADDR_ONHOOK = 8'h48;
    localparam logic [7:0] ADDR_COMMON = 8'h49;
    localparam logic [7:0] ADDR_HIGHBAT = 8'h4a;
    localparam logic [7:0] ADDR_LOWBAT = 8'h4b;
    localparam logic [7:0] ADDR_PWRSEL = 8'h4c;
    localparam logic [7:0] ADDR_PWRREAD = 8'h4d;
    localparam logic [7:0] ADDR_MANUAL = 8'h44;
    localparam int POL_BIT = 6;
    localparam int MAN_CM_BIT = 6;
    localparam int MAN_DIF_BIT = 5;
    localparam logic [5:0] RST_ONHOOK = 6'h20;
    localparam logic [5:0] RST_COMMON = 6'h02;
    localparam logic [5:0] RST_HIGHBAT = 6'h32;
    localparam logic [5:0] RST_LOWBAT = 6'h10;
    localparam logic [2:0] RST_PWRSEL = 3'h0;
    localparam logic [2:0] SEL_LAST = 3'h5;
    localparam int NUM_TRANS = 6;
endpackage

/* verilog/lvsr_pwr_mux.sv */
`timescale 1ns/100ps
`default_nettype none
module lvsr_pwr_mux (
    input wire logic [2:0] i_sel,
    input wire logic [47:0] i_power,
    output logic [7:0] o_reading
);
    // codes above the last transistor read zero
    always_comb begin
        o_reading = 8'h00;
        if (i_sel <= lvsr_pkg::SEL_LAST) begin
            o_reading = i_power[i_sel*8 +: 8];
        end
    end
endmodule
`default_nettype wire

/* verilog/lvsr_regs.sv */
// Overview of operation
// [RULE_01] bit six selects on-hook polarity
// [RULE_02] six-bit on-hook magnitude, 1.5 V steps
// [RULE_03] six-bit common-mode level, 1.5 V steps
// [RULE_04] six-bit high battery level
// [RULE_05] six-bit low battery level, default -24 V
// [RULE_06] software keeps high battery above low
// [RULE_07] software matches external battery rails
// [RULE_08] three-bit selector picks reported transistor
// [RULE_09] software avoids selector codes 110, 111
// [RULE_10] monitor reading follows selected transistor power
// [RULE_11] manual bits make line follow settings
`timescale 1ns/100ps
`default_nettype none
module lvsr_regs (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic [47:0] i_power,
    output logic o_line_polarity_sel,
    output logic [5:0] o_onhook_voltage_level,
    output logic [5:0] o_common_mode_level,
    output logic [5:0] o_high_battery_level,
    output logic [5:0] o_low_battery_level,
    output logic [2:0] o_power_monitor_select,
    output logic o_manual_differential,
    output logic o_manual_common_mode
);
    logic [5:0] onhook_lvl;
    logic [5:0] common_lvl;
    logic [5:0] highbat_lvl;
    logic [5:0] lowbat_lvl;
    logic [7:0] pwr_reading;
    logic [47:0] power_s1_q;
    logic [47:0] power_s2_q;
    logic pol_q;
    logic pol_d;
    logic [2:0] sel_q;
    logic [2:0] sel_d;
    logic man_dif_q;
    logic man_dif_d;
    logic man_cm_q;
    logic man_cm_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic [5:0] line_lvl_q;
    logic [5:0] line_lvl_d;
    logic [5:0] cm_out_q;
    logic [5:0] cm_out_d;
    logic line_pol_q;
    logic line_pol_d;
    logic [2:0] sel_out_q;
    logic [5:0] hb_out_q;
    logic [5:0] lb_out_q;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction

    // [RULE_02] on-hook magnitude field
    lvsr_level_reg #(.RESET_VAL(lvsr_pkg::RST_ONHOOK)) u_onhook (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_we(i_wr && hit(i_addr, lvsr_pkg::ADDR_ONHOOK)),
        .i_wdata(i_wdata[5:0]),
        .o_level(onhook_lvl)
    );
    // [RULE_03] common-mode field
    lvsr_level_reg #(.RESET_VAL(lvsr_pkg::RST_COMMON)) u_common (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_we(i_wr && hit(i_addr, lvsr_pkg::ADDR_COMMON)),
        .i_wdata(i_wdata[5:0]),
        .o_level(common_lvl)
    );
    // [RULE_04] high battery field
    lvsr_level_reg #(.RESET_VAL(lvsr_pkg::RST_HIGHBAT)) u_highbat (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_we(i_wr && hit(i_addr, lvsr_pkg::ADDR_HIGHBAT)),
        .i_wdata(i_wdata[5:0]),
        .o_level(highbat_lvl)
    );
    // [RULE_05] low battery field
    lvsr_level_reg #(.RESET_VAL(lvsr_pkg::RST_LOWBAT)) u_lowbat (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_we(i_wr && hit(i_addr, lvsr_pkg::ADDR_LOWBAT)),
        .i_wdata(i_wdata[5:0]),
        .o_level(lowbat_lvl)
    );

    // [RULE_10] reading of selected transistor
    lvsr_pwr_mux u_mux (
        .i_sel(sel_q),
        .i_power(power_s2_q),
        .o_reading(pwr_reading)
    );

    // power readings come from analog side, other domain
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            power_s1_q <= 48'h0000_0000_0000;
            power_s2_q <= 48'h0000_0000_0000;
        end else begin
            power_s1_q <= i_power;
            power_s2_q <= power_s1_q;
        end
    end

    always_comb begin
        pol_d = pol_q;
        sel_d = sel_q;
        man_dif_d = man_dif_q;
        man_cm_d = man_cm_q;
        if (i_wr) begin
            // [RULE_01] polarity bit write
            if (hit(i_addr, lvsr_pkg::ADDR_ONHOOK)) begin
                pol_d = i_wdata[lvsr_pkg::POL_BIT];
            end
            // [RULE_08] selector write, three bits
            if (hit(i_addr, lvsr_pkg::ADDR_PWRSEL)) begin
                sel_d = i_wdata[2:0];
            end
            // [RULE_11] manual control bits
            if (hit(i_addr, lvsr_pkg::ADDR_MANUAL)) begin
                man_dif_d = i_wdata[lvsr_pkg::MAN_DIF_BIT];
                man_cm_d = i_wdata[lvsr_pkg::MAN_CM_BIT];
            end
        end
    end

    // reserved bits read as zero
    always_comb begin
        rdata_d = 8'h00;
        if (i_rd) begin
            case (i_addr)
                lvsr_pkg::ADDR_ONHOOK: rdata_d = {1'b0, pol_q, onhook_lvl};
                lvsr_pkg::ADDR_COMMON: rdata_d = {2'b00, common_lvl};
                lvsr_pkg::ADDR_HIGHBAT: rdata_d = {2'b00, highbat_lvl};
                lvsr_pkg::ADDR_LOWBAT: rdata_d = {2'b00, lowbat_lvl};
                lvsr_pkg::ADDR_PWRSEL: rdata_d = {5'b00000, sel_q};
                lvsr_pkg::ADDR_PWRREAD: rdata_d = pwr_reading;
                lvsr_pkg::ADDR_MANUAL: rdata_d = {1'b0, man_cm_q, man_dif_q, 5'b00000};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // [RULE_11] manual modes drive line targets; automatic holds last value
    always_comb begin
        line_lvl_d = line_lvl_q;
        line_pol_d = line_pol_q;
        cm_out_d = cm_out_q;
        if (man_dif_q) begin
            line_lvl_d = onhook_lvl;
            line_pol_d = pol_q;
        end
        if (man_cm_q) begin
            cm_out_d = common_lvl;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pol_q <= 1'b0;
            sel_q <= lvsr_pkg::RST_PWRSEL;
            man_dif_q <= 1'b0;
            man_cm_q <= 1'b0;
            rdata_q <= 8'h00;
            line_lvl_q <= lvsr_pkg::RST_ONHOOK;
            line_pol_q <= 1'b0;
            cm_out_q <= lvsr_pkg::RST_COMMON;
            sel_out_q <= lvsr_pkg::RST_PWRSEL;
            hb_out_q <= lvsr_pkg::RST_HIGHBAT;
            lb_out_q <= lvsr_pkg::RST_LOWBAT;
        end else begin
            pol_q <= pol_d;
            sel_q <= sel_d;
            man_dif_q <= man_dif_d;
            man_cm_q <= man_cm_d;
            rdata_q <= rdata_d;
            line_lvl_q <= line_lvl_d;
            line_pol_q <= line_pol_d;
            cm_out_q <= cm_out_d;
            sel_out_q <= sel_q;
            hb_out_q <= highbat_lvl;
            lb_out_q <= lowbat_lvl;
        end
    end

    assign o_rdata = rdata_q;
    assign o_line_polarity_sel = line_pol_q;
    assign o_onhook_voltage_level = line_lvl_q;
    assign o_common_mode_level = cm_out_q;
    assign o_high_battery_level = hb_out_q;
    assign o_low_battery_level = lb_out_q;
    assign o_power_monitor_select = sel_out_q;
    assign o_manual_differential = man_dif_q;
    assign o_manual_common_mode = man_cm_q;
endmodule
`default_nettype wire
